// ===== core/obl_fetch.sv
// sequencer reading both option bytes from the flash information block
`timescale 1ns/1ns
`default_nettype none
module obl_fetch
    import obl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tail,
    obl_load_if.seq ld,
    output logic fl_rd,
    output logic [OBL_FLASH_AW-1:0] fl_addr,
    input wire logic [OBL_DATA_W-1:0] fl_rdata
);
    obl_state_type state_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= OBL_ARMED;
        end else if (ld.ce) begin
            case (state_reg)
                OBL_IDLE: begin
                    if (ld.start) begin
                        state_reg <= OBL_ARMED;
                    end
                end
                OBL_ARMED: begin
                    if (tail) begin
                        state_reg <= OBL_REQ0;
                    end
                end
                OBL_REQ0: state_reg <= OBL_CAP0;
                OBL_CAP0: state_reg <= OBL_REQ1;
                OBL_REQ1: state_reg <= OBL_CAP1;
                OBL_CAP1: state_reg <= OBL_IDLE;
                default: state_reg <= OBL_IDLE;
            endcase
        end
    end

    always_comb begin
        fl_rd = ld.ce && (state_reg == OBL_REQ0 || state_reg == OBL_REQ1);
        fl_addr = (state_reg == OBL_REQ1) ? OBL_BYTE1_FLASH_ADDR : OBL_BYTE0_FLASH_ADDR;
    end

    // flash data is valid the cycle after the read request
    assign ld.strobe = ld.ce && (state_reg == OBL_CAP0 || state_reg == OBL_CAP1);
    assign ld.sel = (state_reg == OBL_CAP1) ? OBL_SEL_BYTE1 : OBL_SEL_BYTE0;
    assign ld.data = fl_rdata;
    assign ld.busy = (state_reg != OBL_IDLE);
endmodule
`default_nettype wire

// ===== core/obl_load_if.sv
// load strobes from the flash sequencer to the shadow registers
`timescale 1ns/1ns
`default_nettype none
interface obl_load_if;
    import obl_pkg::*;
    logic ce;
    logic start;
    logic busy;
    logic strobe;
    logic sel;
    logic [OBL_DATA_W-1:0] data;
    modport seq (input ce, input start, output busy, output strobe, output sel, output data);
    modport sink (input ce, input start, input strobe, input sel, input data);
    modport ctl (output ce, output start, input busy, input strobe, input sel, input data);
endinterface
`default_nettype wire

// ===== core/obl_loader.sv
// option byte shadow loader: fetch at reset tail, shadows, protection, register access
// What this block does
// - load options on power-on or enabled recovery reset
// - feature enables come from shadow outputs
// - flash changes apply only after reset
// - some shadows preset at reset start
// - option bytes fetched from FEh and FFh
// - byte 0 shadow unknown until loaded
// - cpu read/write shadows except byte1 bits 1:0
// - byte 0 shadow at address D0Eh
// - byte 0 bit 7 picks watchdog mode
// - byte 0 bits 6:0 active-low pull-ups
// - option byte 1 never programmed by cpu
// - power-on samples protection bits into flops
// - protection flops readable at own address
// - cpu writes to protection flops ignored
// - byte 1 layout: reserved, stack, divide, protects
// - divide select halves crystal when recovery bit0 low
// - stack select limits stack to 8 bits
`timescale 1ns/1ns
`default_nettype none
module obl_loader
    import obl_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic RESET_TAIL,
    input wire logic RECOVERY_RESET,
    input wire logic [7:0] STOP_RECOVERY_REG,
    output logic RESET_HOLD,
    output logic FL_RD,
    output logic [OBL_FLASH_AW-1:0] FL_ADDR,
    input wire logic [OBL_DATA_W-1:0] FL_RDATA,
    input wire logic [OBL_REG_AW-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [OBL_DATA_W-1:0] REG_WDATA,
    output logic [OBL_DATA_W-1:0] REG_RDATA,
    input wire logic CPU_PROG_REQ,
    input wire logic [OBL_FLASH_AW-1:0] CPU_PROG_ADDR,
    output logic CPU_PROG_DENY,
    output logic WATCHDOG_ALWAYS_ON,
    output logic [OBL_PULLUP_MSB:0] PULLUP_EN,
    output logic STACK_8BIT,
    output logic SYSCLK_DIV2,
    output logic LOWER_HALF_PROTECT_N,
    output logic FLASH_RW_PROTECT_N,
    output logic OPT_VALID
);
    obl_load_if ld ();

    logic por_load_reg;
    logic valid_reg;
    logic [1:0] prot_reg;
    logic [OBL_DATA_W-1:0] rdata_reg;
    logic [OBL_DATA_W-1:0] byte0_q;
    logic [OBL_DATA_W-1:0] byte1_q;
    logic recov_start;
    logic byte0_we;
    logic byte1_we;

    assign ld.ce = CE;

    // recovery reset reloads only with its load bit set
    // no other path starts a reload
    assign recov_start = RECOVERY_RESET && STOP_RECOVERY_REG[OBL_RECOV_LOAD_BIT];
    assign ld.start = recov_start && !ld.busy;

    // first load after RST_N release is the power-on load
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            por_load_reg <= 1'b1;
        end else if (CE) begin
            if (ld.strobe && ld.sel == OBL_SEL_BYTE1) begin
                por_load_reg <= 1'b0;
            end
        end
    end

    // shadows are valid after the first complete fetch
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            valid_reg <= 1'b0;
        end else if (CE) begin
            if (ld.strobe && ld.sel == OBL_SEL_BYTE1) begin
                valid_reg <= 1'b1;
            end
        end
    end

    obl_fetch u_fetch (
        .clk(CLK),
        .rst_n(RST_N),
        .tail(RESET_TAIL),
        .ld(ld.seq),
        .fl_rd(FL_RD),
        .fl_addr(FL_ADDR),
        .fl_rdata(FL_RDATA)
    );

    assign byte0_we = CE && REG_WR && REG_ADDR == OBL_BYTE0_SHADOW_ADDR;
    assign byte1_we = CE && REG_WR && REG_ADDR == OBL_BYTE1_SHADOW_ADDR;

    // byte 0 has no reset value
    obl_shadow #(
        .SEL(OBL_SEL_BYTE0),
        .PRESET_EN(1'b0),
        .WR_MASK(OBL_BYTE0_WR_MASK)
    ) u_byte0 (
        .clk(CLK),
        .rst_n(RST_N),
        .ld(ld.sink),
        .cpu_we(byte0_we),
        .cpu_wdata(REG_WDATA),
        .q(byte0_q)
    );

    // byte 1 bits 1:0 not writable
    // byte 1 preset to erased value
    obl_shadow #(
        .SEL(OBL_SEL_BYTE1),
        .PRESET_EN(1'b1),
        .WR_MASK(OBL_BYTE1_WR_MASK)
    ) u_byte1 (
        .clk(CLK),
        .rst_n(RST_N),
        .ld(ld.sink),
        .cpu_we(byte1_we),
        .cpu_wdata(REG_WDATA),
        .q(byte1_q)
    );

    // reset to protected until the power-on sample arrives
    // sample protection bits on power-on load
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            prot_reg <= OBL_PROT_RESET;
        end else if (CE) begin
            if (ld.strobe && ld.sel == OBL_SEL_BYTE1 && por_load_reg) begin
                prot_reg <= {ld.data[OBL_LOWER_PROT_BIT], ld.data[OBL_RW_PROT_BIT]};
            end
        end
    end

    // registered read data, unmapped addresses read zero
    // protection flops readable
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_reg <= OBL_ZERO_BYTE;
        end else if (CE && REG_RD) begin
            case (REG_ADDR)
                OBL_BYTE0_SHADOW_ADDR: rdata_reg <= byte0_q;
                OBL_BYTE1_SHADOW_ADDR: rdata_reg <= byte1_q;
                OBL_PROT_STATUS_ADDR: rdata_reg <= {6'h00, prot_reg};
                default: rdata_reg <= OBL_ZERO_BYTE;
            endcase
        end
    end
    assign REG_RDATA = rdata_reg;

    // cpu byte-programming of option byte 1 refused
    // reserved bits only reach flash through the in-circuit port
    assign CPU_PROG_DENY = CPU_PROG_REQ && CPU_PROG_ADDR == OBL_BYTE1_FLASH_ADDR;

    assign RESET_HOLD = ld.busy;
    assign OPT_VALID = valid_reg;

    assign WATCHDOG_ALWAYS_ON = ~byte0_q[OBL_WATCHDOG_BIT];
    assign PULLUP_EN = ~byte0_q[OBL_PULLUP_MSB:0];
    assign STACK_8BIT = byte1_q[OBL_STACK_BIT];
    // halving only while recovery bit 0 low
    assign SYSCLK_DIV2 = byte1_q[OBL_DIV_BIT] && !STOP_RECOVERY_REG[OBL_RECOV_DIV_BIT];
    assign LOWER_HALF_PROTECT_N = prot_reg[1];
    assign FLASH_RW_PROTECT_N = prot_reg[0];
endmodule
`default_nettype wire

// ===== core/obl_pkg.sv
// shared constants and types of the option byte shadow loader
package obl_pkg;
    localparam int OBL_DATA_W = 8;
    localparam int OBL_REG_AW = 12;
    localparam int OBL_FLASH_AW = 8;
    localparam logic [11:0] OBL_BYTE0_SHADOW_ADDR = 12'hD0E;
    localparam logic [11:0] OBL_BYTE1_SHADOW_ADDR = 12'hD0F;
    localparam logic [11:0] OBL_PROT_STATUS_ADDR = 12'hD0D;
    localparam logic [7:0] OBL_BYTE0_FLASH_ADDR = 8'hFE;
    localparam logic [7:0] OBL_BYTE1_FLASH_ADDR = 8'hFF;
    localparam logic [7:0] OBL_OPT_PRESET = 8'hFF;
    localparam logic [7:0] OBL_BYTE0_WR_MASK = 8'hFF;
    localparam logic [7:0] OBL_BYTE1_WR_MASK = 8'hFC;
    localparam logic [7:0] OBL_ZERO_BYTE = 8'h00;
    localparam logic [1:0] OBL_PROT_RESET = 2'h0;
    localparam int OBL_WATCHDOG_BIT = 7;
    localparam int OBL_PULLUP_MSB = 6;
    localparam int OBL_STACK_BIT = 3;
    localparam int OBL_DIV_BIT = 2;
    localparam int OBL_LOWER_PROT_BIT = 1;
    localparam int OBL_RW_PROT_BIT = 0;
    localparam int OBL_RECOV_LOAD_BIT = 5;
    localparam int OBL_RECOV_DIV_BIT = 0;
    localparam logic OBL_SEL_BYTE0 = 1'b0;
    localparam logic OBL_SEL_BYTE1 = 1'b1;
    typedef enum {
        OBL_IDLE, OBL_ARMED, OBL_REQ0, OBL_CAP0, OBL_REQ1, OBL_CAP1
    } obl_state_type;
endpackage

// ===== core/obl_shadow.sv
// one option byte shadow register with load, preset and masked cpu write
`timescale 1ns/1ns
`default_nettype none
module obl_shadow
    import obl_pkg::*;
#(
    parameter logic SEL = 1'b0,
    parameter bit PRESET_EN = 1'b0,
    parameter logic [7:0] WR_MASK = 8'hFF
) (
    input wire logic clk,
    input wire logic rst_n,
    obl_load_if.sink ld,
    input wire logic cpu_we,
    input wire logic [OBL_DATA_W-1:0] cpu_wdata,
    output logic [OBL_DATA_W-1:0] q
);
    logic [OBL_DATA_W-1:0] q_reg;
    logic [OBL_DATA_W-1:0] q_next;

    // load from flash wins over a cpu write in the same cycle
    always_comb begin
        q_next = q_reg;
        if (PRESET_EN && ld.start) begin
            q_next = OBL_OPT_PRESET;
        end
        if (cpu_we) begin
            q_next = (q_reg & ~WR_MASK) | (cpu_wdata & WR_MASK);
        end
        if (ld.strobe && ld.sel == SEL) begin
            q_next = ld.data;
        end
    end

    generate
        if (PRESET_EN) begin : g_preset
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    q_reg <= OBL_OPT_PRESET;
                end else if (ld.ce) begin
                    q_reg <= q_next;
                end
            end
        end else begin : g_plain
            always_ff @(posedge clk) begin
                if (ld.ce) begin
                    q_reg <= q_next;
                end
            end
        end
    endgenerate

    assign q = q_reg;
endmodule
`default_nettype wire

// ===== test/obl_flash_model.sv
// flash information block model answering option byte reads
`timescale 1ns/1ns
`default_nettype none
module obl_flash_model
    import obl_pkg::*;
(
    input wire logic clk,
    input wire logic fl_rd,
    input wire logic [7:0] fl_addr,
    input wire logic [7:0] user_option_byte_zero_img,
    input wire logic [7:0] user_option_byte_one_img,
    output logic [7:0] fl_rdata
);
    initial fl_rdata = 8'h5A;
    always @(posedge clk) begin
        if (fl_rd) begin
            fl_rdata <= (fl_addr == OBL_BYTE1_FLASH_ADDR) ? {4'hF, user_option_byte_one_img[3:0]} : user_option_byte_zero_img;
        end else begin
            // released bus toggles so stale data never looks valid
            fl_rdata <= ~fl_rdata;
        end
    end
endmodule
`default_nettype wire

// ===== test/obl_loader_sva.sv
// port assertions of the option byte shadow loader
`timescale 1ns/1ns
`default_nettype none
module obl_loader_sva
    import obl_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [11:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] STOP_RECOVERY_REG,
    input wire logic FL_RD,
    input wire logic [7:0] FL_ADDR,
    input wire logic RESET_HOLD,
    input wire logic OPT_VALID,
    input wire logic WATCHDOG_ALWAYS_ON,
    input wire logic [6:0] PULLUP_EN,
    input wire logic STACK_8BIT,
    input wire logic SYSCLK_DIV2,
    input wire logic LOWER_HALF_PROTECT_N,
    input wire logic FLASH_RW_PROTECT_N
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_rd0; FL_RD && FL_ADDR == OBL_BYTE0_FLASH_ADDR; endsequence
    sequence s_rd1; FL_RD && FL_ADDR == OBL_BYTE1_FLASH_ADDR; endsequence
    property p_order; s_rd0 ##1 CE [*2] |-> s_rd1; endproperty
    property p_release; s_rd1 ##1 CE |=> !RESET_HOLD && OPT_VALID; endproperty
    property p_pulse; FL_RD |=> !FL_RD; endproperty
    property p_hold; FL_RD |-> RESET_HOLD; endproperty
    property p_byte0; CE && REG_WR && !RESET_HOLD && REG_ADDR == OBL_BYTE0_SHADOW_ADDR
        |=> {WATCHDOG_ALWAYS_ON, PULLUP_EN} == ~$past(REG_WDATA); endproperty
    property p_byte1; CE && REG_WR && !RESET_HOLD && REG_ADDR == OBL_BYTE1_SHADOW_ADDR
        |=> STACK_8BIT == $past(REG_WDATA[OBL_STACK_BIT]); endproperty
    property p_div; STOP_RECOVERY_REG[OBL_RECOV_DIV_BIT] |-> !SYSCLK_DIV2; endproperty
    property p_prot; CE && REG_WR && !RESET_HOLD && REG_ADDR == OBL_PROT_STATUS_ADDR
        |=> $stable(LOWER_HALF_PROTECT_N) && $stable(FLASH_RW_PROTECT_N); endproperty
    a_order: assert property (p_order) else $error("byte one read missing");
    a_release: assert property (p_release) else $error("hold not released");
    a_pulse: assert property (p_pulse) else $error("read strobe too long");
    a_hold: assert property (p_hold) else $error("read outside hold");
    a_byte0: assert property (p_byte0) else $error("byte zero outputs wrong");
    a_byte1: assert property (p_byte1) else $error("stack select wrong");
    a_div: assert property (p_div) else $error("divide not gated");
    a_prot: assert property (p_prot) else $error("protection changed");
endmodule
bind obl_loader obl_loader_sva i_obl_loader_sva (.CLK, .RST_N, .CE, .REG_ADDR, .REG_WR, .REG_WDATA,
    .STOP_RECOVERY_REG, .FL_RD, .FL_ADDR, .RESET_HOLD, .OPT_VALID, .WATCHDOG_ALWAYS_ON, .PULLUP_EN,
    .STACK_8BIT, .SYSCLK_DIV2, .LOWER_HALF_PROTECT_N, .FLASH_RW_PROTECT_N);
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench of the option byte shadow loader
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import obl_pkg::*;
    logic CLK, RST_N, CE, RESET_TAIL, RECOVERY_RESET, REG_WR, REG_RD, CPU_PROG_REQ, FL_RD, RESET_HOLD;
    logic OPT_VALID, WATCHDOG_ALWAYS_ON, STACK_8BIT, SYSCLK_DIV2, LOWER_HALF_PROTECT_N, FLASH_RW_PROTECT_N;
    logic CPU_PROG_DENY, go;
    logic [7:0] STOP_RECOVERY_REG, FL_ADDR, FL_RDATA, REG_WDATA, REG_RDATA, CPU_PROG_ADDR, o0, o1, f0, f1;
    logic [11:0] REG_ADDR;
    logic [6:0] PULLUP_EN;
    logic [31:0] seed;
    logic [9:0] q[$];
    logic [9:0] e;
    int error_cnt, checks, i;
    obl_loader i_obl_loader (.CLK, .RST_N, .CE, .RESET_TAIL, .RECOVERY_RESET, .STOP_RECOVERY_REG, .RESET_HOLD,
        .FL_RD, .FL_ADDR, .FL_RDATA, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA, .CPU_PROG_REQ,
        .CPU_PROG_ADDR, .CPU_PROG_DENY, .WATCHDOG_ALWAYS_ON, .PULLUP_EN, .STACK_8BIT, .SYSCLK_DIV2,
        .LOWER_HALF_PROTECT_N, .FLASH_RW_PROTECT_N, .OPT_VALID);
    obl_flash_model i_obl_flash_model (.clk(CLK), .fl_rd(FL_RD), .fl_addr(FL_ADDR), .user_option_byte_zero_img(f0),
        .user_option_byte_one_img(f1), .fl_rdata(FL_RDATA));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] obs(input logic [1:0] s);
        case (s)
            2'h0: return REG_RDATA;
            2'h1: return {WATCHDOG_ALWAYS_ON, PULLUP_EN};
            2'h2: return {4'h0, STACK_8BIT, SYSCLK_DIV2, LOWER_HALF_PROTECT_N, FLASH_RW_PROTECT_N};
            default: return {RESET_HOLD, OPT_VALID, CPU_PROG_DENY, 5'h00};
        endcase
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // monitor takes the oldest note whenever a result is due
    always @(posedge CLK) begin
        if (go && q.size() > 0) begin
            e = q.pop_front();
            check($sformatf("group %0d", e[9:8]), obs(e[9:8]), e[7:0]);
        end
    end
    task automatic step;
        @(posedge CLK);
        #1;
    endtask
    task automatic chk(input logic [1:0] s, input logic [7:0] x);
        q.push_back({s, x});
        go = 1;
        step;
        go = 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1;
        step;
        REG_WR = 0;
        step;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        REG_ADDR = a;
        REG_RD = 1;
        step;
        REG_RD = 0;
        chk(2'h0, x);
    endtask
    task automatic fetch;
        int n;
        RESET_TAIL = 1;
        step;
        RESET_TAIL = 0;
        for (n = 0; n < 20 && RESET_HOLD !== 1'b0; n++) step;
    endtask
    task automatic wrap_up;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        CLK = 0;
        forever #10 CLK = ~CLK;
    end
    // whole sequence needs about 130 cycles
    initial begin
        #100000;
        error_cnt++;
        wrap_up;
    end
    initial begin
        RST_N = 0; CE = 1; RESET_TAIL = 0; RECOVERY_RESET = 0; REG_WR = 0; REG_RD = 0; CPU_PROG_REQ = 0;
        STOP_RECOVERY_REG = 8'h00; REG_ADDR = 12'h000; REG_WDATA = 8'h00; CPU_PROG_ADDR = 8'h00; go = 0;
        error_cnt = 0; checks = 0; seed = xs(32'h98F5AD26);
        o0 = seed[7:0]; o1 = {4'hF, seed[11:8]}; f0 = o0; f1 = o1;
        repeat (20) @(posedge CLK);
        #1 RST_N = 1;
        step;
        chk(2'h3, 8'h80);
        fetch;
        chk(2'h3, 8'h40);
        chk(2'h1, ~o0);
        chk(2'h2, {4'h0, o1[3:0]});
        rd(OBL_BYTE0_SHADOW_ADDR, o0);
        rd(OBL_PROT_STATUS_ADDR, {6'h00, o1[1:0]});
        for (i = 0; i < 6; i++) begin
            seed = xs(seed);
            wr(OBL_BYTE0_SHADOW_ADDR, seed[7:0]);
            chk(2'h1, ~seed[7:0]);
            wr(OBL_BYTE1_SHADOW_ADDR, seed[15:8]);
            rd(OBL_BYTE1_SHADOW_ADDR, (seed[15:8] & 8'hFC) | (o1 & 8'h03));
            wr(OBL_PROT_STATUS_ADDR, seed[23:16]);
            rd(OBL_PROT_STATUS_ADDR, {6'h00, o1[1:0]});
        end
        rd(12'hD0C, 8'h00);
        STOP_RECOVERY_REG = 8'h01;
        wr(OBL_BYTE1_SHADOW_ADDR, 8'hFF);
        chk(2'h2, 8'h08 | (o1 & 8'h03));
        STOP_RECOVERY_REG = 8'h00;
        chk(2'h2, 8'h0C | (o1 & 8'h03));
        wr(OBL_BYTE0_SHADOW_ADDR, o0);
        // clear stack and divide so that only the preset can raise them
        wr(OBL_BYTE1_SHADOW_ADDR, 8'h00);
        chk(2'h2, {6'h00, o1[1:0]});
        // frozen clock enable drops the write
        CE = 0;
        wr(OBL_BYTE0_SHADOW_ADDR, ~o0);
        CE = 1;
        chk(2'h1, ~o0);
        seed = xs(seed);
        f0 = seed[7:0];
        f1 = {4'hF, seed[11:8]};
        // recovery without the reload bit keeps old options
        RECOVERY_RESET = 1;
        step;
        RECOVERY_RESET = 0;
        chk(2'h1, ~o0);
        chk(2'h3, 8'h40);
        STOP_RECOVERY_REG = 8'h20;
        RECOVERY_RESET = 1;
        step;
        RECOVERY_RESET = 0;
        chk(2'h2, 8'h0C | (o1 & 8'h03));
        fetch;
        chk(2'h1, ~f0);
        chk(2'h2, {4'h0, f1[3:2], o1[1:0]});
        CPU_PROG_REQ = 1;
        CPU_PROG_ADDR = OBL_BYTE1_FLASH_ADDR;
        chk(2'h3, 8'h60);
        CPU_PROG_ADDR = OBL_BYTE0_FLASH_ADDR;
        chk(2'h3, 8'h40);
        wrap_up;
    end
endmodule
`default_nettype wire
